/* shared/mdbc_defines.svh */
// constants of the motor drive bus control block
`ifndef MDBC_DEFINES_SVH
`define MDBC_DEFINES_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define MDBC_CLK_NS     4
`define MDBC_TICK_US    500
`define MDBC_TICK_CYC   ((`MDBC_TICK_US * 1000) / `MDBC_CLK_NS)
`define MDBC_KEY_US     500000
`define MDBC_KEY_TICKS  (`MDBC_KEY_US / `MDBC_TICK_US)
`define MDBC_SEQ_US     18500
`define MDBC_SEQ_TICKS  (((`MDBC_SEQ_US + `MDBC_TICK_US - 1) / `MDBC_TICK_US) + 1)
// ----------------------------------------
// frequencies in Hz, ramps in 0.1 s
// ----------------------------------------
`define MDBC_F1_HZ      6'h1E
`define MDBC_F2_HZ      6'h28
`define MDBC_F3_HZ      6'h32
`define MDBC_POT_MAX_HZ 6'h32
`define MDBC_ACC_RST    16'h0064
`define MDBC_DEC_RST    16'h0014
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MDBC_REG_CTRL   8'h00
`define MDBC_REG_ACC    8'h04
`define MDBC_REG_DEC    8'h08
`define MDBC_REG_STAT   8'h0C
`define MDBC_REG_IRQS   8'h10
`define MDBC_REG_IRQM   8'h14
`define MDBC_REG_FAULT  8'h18
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define MDBC_CTRL_ENH   0
`define MDBC_CTRL_EXT   1
`define MDBC_CTRL_RST   2'h0
`define MDBC_IRQ_FAULT  0
`define MDBC_IRQ_KEYCLR 1
`define MDBC_IRQ_BUSRST 2
`define MDBC_IRQ_BLOCK  3
`define MDBC_IRQ_RST    4'h0
`define MDBC_IN_RST     4'h2
`define MDBC_FLT_MOTOR  6
`endif

/* shared/mdbc_pkg.sv */
// types of the motor drive bus control block
package mdbc_pkg;
    typedef enum logic [1:0] {
        MDBC_KEY_OFF  = 2'b00,
        MDBC_KEY_HAND = 2'b01,
        MDBC_KEY_AUTO = 2'b10
    } mdbc_key_t;

    typedef enum logic [1:0] {
        MDBC_SEQ_IDLE = 2'b00,
        MDBC_SEQ_LOW  = 2'b01,
        MDBC_SEQ_HIGH = 2'b10,
        MDBC_SEQ_DONE = 2'b11
    } mdbc_seq_t;

    typedef struct packed {
        logic [3:0]  out_bits;
        logic [3:0]  in_bits;
        logic [1:0]  ctrl;
        logic [15:0] acc;
        logic [15:0] dec;
        logic [6:0]  lat;
        logic [3:0]  irq_st;
        logic [3:0]  irq_mk;
        logic [17:0] tick_cnt;
        logic [10:0] key_cnt;
        logic [5:0]  seq_cnt;
        mdbc_seq_t   seq;
        logic        st_done;
        logic        blocked;
        logic        sup_q;
        logic [31:0] rdata;
        logic        run_cw;
        logic        run_ccw;
        logic [5:0]  ref_freq;
    } mdbc_state_t;
endpackage

/* logic/mdbc_top.sv */
// motor drive bus control: bus bits, faults, key reset, bus reset sequence
//
// What this block does
// - in automatic, forward bit alone runs clockwise, reverse bit alone anticlockwise, both or neither mean no enable.
// - frequency-select bits pick 30, 40 or 50 Hz as a binary code.
// - with no frequency-select bit the potentiometer value, limited to 0 to 50 Hz, is used.
// - all power stage faults form one group error, error bit reads 0 on error, mode bit reads 1 in automatic.
// - the third and fourth input bits show external inputs a and b, 1 when applied.
// - a power stage fault, or a motor fault on the standard variant, removes drive so the motor coasts.
// - on the enhanced variant a motor fault stops the motor with the default deceleration ramp.
// - holding the key-switch in Off for about 0.5 s clears a latched error, shorter presses do nothing.
// - on the enhanced variant in automatic both direction bits set is a bus reset request, not a run.
// - the reset happens only after both bits low for 18.5 ms and then high for 18.5 ms.
// - after self-test the power stage faults are detected and readable over the register port.
// - on the enhanced variant the motor fault is a separate diagnostic status.
// - a replacement unit with the key in Off clears all errors within 0.5 s.
// - out of reset the ramps are 10 s acceleration and 2 s deceleration.
// - after supply return in manual mode restart is blocked until the key is turned to Off.
`timescale 1ns/1ps
`include "mdbc_defines.svh"
module mdbc_top #(
    parameter int TICK_CYC = `MDBC_TICK_CYC
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        XCHG,
    input  wire logic [3:0]  OUT_BITS,
    output      logic [3:0]  IN_BITS,
    input  wire logic [1:0]  KEY_POS,
    input  wire logic        HAND_CW,
    input  wire logic        HAND_CCW,
    input  wire logic        SELFTEST_DONE,
    input  wire logic        SUPPLY_OK,
    input  wire logic [5:0]  PWR_FAULT,
    input  wire logic        MOTOR_FAULT,
    input  wire logic        EXTERNAL_INPUT_A,
    input  wire logic        EXTERNAL_INPUT_B,
    input  wire logic [5:0]  POT_FREQ,
    output      logic        RUN_CW,
    output      logic        RUN_CCW,
    output      logic [5:0]  REF_FREQ,
    output      logic        COAST,
    output      logic        RAMP_STOP,
    output      logic        MOTOR_DIAG,
    output      logic [15:0] ACC_TIME,
    output      logic [15:0] DEC_TIME,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output      logic [31:0] RDATA,
    output      logic        IRQ
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    mdbc_pkg::mdbc_state_t st;
    mdbc_pkg::mdbc_state_t next_st;

    logic       enh;
    logic       auto_mode;
    logic       key_off;
    logic       tick;
    logic       both_low;
    logic       both_high;
    logic       group_err;
    logic       coast;
    logic       ramp_stop;
    logic       key_clear;
    logic       bus_clear;
    logic       clear_err;
    logic [6:0] fault_in;
    logic [3:0] irq_ev;
    logic [5:0] pot_hz;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    always_comb begin
        enh       = st.ctrl[`MDBC_CTRL_ENH];
        auto_mode = (mdbc_pkg::mdbc_key_t'(KEY_POS) == mdbc_pkg::MDBC_KEY_AUTO);
        key_off   = (mdbc_pkg::mdbc_key_t'(KEY_POS) == mdbc_pkg::MDBC_KEY_OFF);
        tick      = (st.tick_cnt == 18'(TICK_CYC - 1));
        both_low  = ~st.out_bits[0] & ~st.out_bits[1];
        both_high = st.out_bits[0] & st.out_bits[1];
        if (st.st_done) begin
            fault_in = {MOTOR_FAULT, PWR_FAULT};
        end else begin
            fault_in = 7'h00;
        end
        group_err = |st.lat;
        coast     = (|st.lat[5:0]) | (st.lat[`MDBC_FLT_MOTOR] & ~enh);
        ramp_stop = st.lat[`MDBC_FLT_MOTOR] & enh & ~coast;
        key_clear = key_off & tick & (st.key_cnt == 11'(`MDBC_KEY_TICKS - 1));
        bus_clear = tick & (st.seq == mdbc_pkg::MDBC_SEQ_HIGH)
                  & (st.seq_cnt == 6'(`MDBC_SEQ_TICKS - 1)) & both_high;
        clear_err = key_clear | bus_clear;
        if (POT_FREQ > `MDBC_POT_MAX_HZ) begin
            pot_hz = `MDBC_POT_MAX_HZ;
        end else begin
            pot_hz = POT_FREQ;
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        irq_ev  = 4'h0;

        // ----------------------------------------
        // half-millisecond tick
        // ----------------------------------------
        if (tick) begin
            next_st.tick_cnt = 18'h00000;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 18'h00001;
        end

        // ----------------------------------------
        // self-test completion
        // ----------------------------------------
        if (SELFTEST_DONE) begin
            next_st.st_done = 1'b1;
        end

        // ----------------------------------------
        // bus exchange
        // ----------------------------------------
        if (XCHG) begin
            next_st.out_bits = OUT_BITS;
            next_st.in_bits  = {EXTERNAL_INPUT_B & st.ctrl[`MDBC_CTRL_EXT],
                                EXTERNAL_INPUT_A & st.ctrl[`MDBC_CTRL_EXT],
                                ~group_err, auto_mode};
        end

        // ----------------------------------------
        // key-switch hold timer
        // ----------------------------------------
        if (!key_off) begin
            next_st.key_cnt = 11'h000;
        end else if (tick && st.key_cnt != 11'(`MDBC_KEY_TICKS)) begin
            next_st.key_cnt = st.key_cnt + 11'h001;
        end

        // ----------------------------------------
        // bus reset sequence
        // ----------------------------------------
        if (!(enh && auto_mode)) begin
            next_st.seq     = mdbc_pkg::MDBC_SEQ_IDLE;
            next_st.seq_cnt = 6'h00;
        end else begin
            case (st.seq)
                mdbc_pkg::MDBC_SEQ_IDLE: begin
                    next_st.seq_cnt = 6'h00;
                    if (both_low) begin
                        next_st.seq = mdbc_pkg::MDBC_SEQ_LOW;
                    end
                end
                mdbc_pkg::MDBC_SEQ_LOW: begin
                    if (both_high && st.seq_cnt == 6'(`MDBC_SEQ_TICKS)) begin
                        next_st.seq     = mdbc_pkg::MDBC_SEQ_HIGH;
                        next_st.seq_cnt = 6'h00;
                    end else if (!both_low) begin
                        next_st.seq = mdbc_pkg::MDBC_SEQ_IDLE;
                    end else if (tick && st.seq_cnt != 6'(`MDBC_SEQ_TICKS)) begin
                        next_st.seq_cnt = st.seq_cnt + 6'h01;
                    end
                end
                mdbc_pkg::MDBC_SEQ_HIGH: begin
                    if (!both_high) begin
                        if (both_low) begin
                            next_st.seq = mdbc_pkg::MDBC_SEQ_LOW;
                        end else begin
                            next_st.seq = mdbc_pkg::MDBC_SEQ_IDLE;
                        end
                        next_st.seq_cnt = 6'h00;
                    end else if (bus_clear) begin
                        next_st.seq = mdbc_pkg::MDBC_SEQ_DONE;
                        irq_ev[`MDBC_IRQ_BUSRST] = 1'b1;
                    end else if (tick) begin
                        next_st.seq_cnt = st.seq_cnt + 6'h01;
                    end
                end
                mdbc_pkg::MDBC_SEQ_DONE: begin
                    if (!both_high) begin
                        next_st.seq     = mdbc_pkg::MDBC_SEQ_IDLE;
                        next_st.seq_cnt = 6'h00;
                    end
                end
                default: begin
                    next_st.seq = mdbc_pkg::MDBC_SEQ_IDLE;
                end
            endcase
        end

        // ----------------------------------------
        // fault latch, a new fault wins over the clear
        // ----------------------------------------
        next_st.lat = (clear_err ? 7'h00 : st.lat) | fault_in;
        if (|(fault_in & ~st.lat)) begin
            irq_ev[`MDBC_IRQ_FAULT] = 1'b1;
        end
        if (key_clear) begin
            irq_ev[`MDBC_IRQ_KEYCLR] = 1'b1;
        end

        // ----------------------------------------
        // restart block after supply return in manual mode
        // ----------------------------------------
        next_st.sup_q = SUPPLY_OK;
        if (SUPPLY_OK && !st.sup_q && !auto_mode && !key_off) begin
            next_st.blocked = 1'b1;
            irq_ev[`MDBC_IRQ_BLOCK] = 1'b1;
        end else if (key_off) begin
            next_st.blocked = 1'b0;
        end

        // ----------------------------------------
        // drive commands
        // ----------------------------------------
        next_st.run_cw  = 1'b0;
        next_st.run_ccw = 1'b0;
        if (!coast && !ramp_stop && !st.blocked && SUPPLY_OK) begin
            if (auto_mode) begin
                next_st.run_cw  = st.out_bits[0] & ~st.out_bits[1];
                next_st.run_ccw = st.out_bits[1] & ~st.out_bits[0];
            end else if (!key_off) begin
                next_st.run_cw  = HAND_CW & ~HAND_CCW;
                next_st.run_ccw = HAND_CCW & ~HAND_CW;
            end
        end
        case (st.out_bits[3:2])
            2'b01: begin
                next_st.ref_freq = `MDBC_F1_HZ;
            end
            2'b10: begin
                next_st.ref_freq = `MDBC_F2_HZ;
            end
            2'b11: begin
                next_st.ref_freq = `MDBC_F3_HZ;
            end
            default: begin
                next_st.ref_freq = pot_hz;
            end
        endcase

        // ----------------------------------------
        // register writes
        // ----------------------------------------
        if (WR) begin
            case (ADDR)
                `MDBC_REG_CTRL: begin
                    next_st.ctrl = WDATA[1:0];
                end
                `MDBC_REG_ACC: begin
                    next_st.acc = WDATA[15:0];
                end
                `MDBC_REG_DEC: begin
                    next_st.dec = WDATA[15:0];
                end
                `MDBC_REG_IRQS: begin
                    next_st.irq_st = st.irq_st & ~WDATA[3:0];
                end
                `MDBC_REG_IRQM: begin
                    next_st.irq_mk = WDATA[3:0];
                end
                default: begin
                end
            endcase
        end
        next_st.irq_st = next_st.irq_st | irq_ev;

        // ----------------------------------------
        // register reads, answered in the next cycle
        // ----------------------------------------
        next_st.rdata = 32'h00000000;
        if (RD) begin
            case (ADDR)
                `MDBC_REG_CTRL: begin
                    next_st.rdata = {30'h0000000, st.ctrl};
                end
                `MDBC_REG_ACC: begin
                    next_st.rdata = {16'h0000, st.acc};
                end
                `MDBC_REG_DEC: begin
                    next_st.rdata = {16'h0000, st.dec};
                end
                `MDBC_REG_STAT: begin
                    next_st.rdata = {20'h00000, st.seq, st.blocked, st.st_done,
                                     ramp_stop, coast, group_err, 1'b0, st.in_bits};
                end
                `MDBC_REG_IRQS: begin
                    next_st.rdata = {28'h0000000, st.irq_st};
                end
                `MDBC_REG_IRQM: begin
                    next_st.rdata = {28'h0000000, st.irq_mk};
                end
                `MDBC_REG_FAULT: begin
                    next_st.rdata = {25'h000000, st.lat};
                end
                default: begin
                    next_st.rdata = 32'h00000000;
                end
            endcase
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st          <= '0;
            st.in_bits  <= `MDBC_IN_RST;
            st.sup_q    <= 1'b1;
            st.ctrl     <= `MDBC_CTRL_RST;
            st.acc      <= `MDBC_ACC_RST;
            st.dec      <= `MDBC_DEC_RST;
            st.irq_st   <= `MDBC_IRQ_RST;
            st.irq_mk   <= `MDBC_IRQ_RST;
            st.seq      <= mdbc_pkg::MDBC_SEQ_IDLE;
            st.ref_freq <= 6'h00;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_comb begin
        IN_BITS    = st.in_bits;
        RUN_CW     = st.run_cw;
        RUN_CCW    = st.run_ccw;
        REF_FREQ   = st.ref_freq;
        COAST      = coast;
        RAMP_STOP  = ramp_stop;
        MOTOR_DIAG = enh & st.lat[`MDBC_FLT_MOTOR];
        ACC_TIME   = st.acc;
        DEC_TIME   = st.dec;
        RDATA      = st.rdata;
        IRQ        = |(st.irq_st & st.irq_mk);
    end
endmodule

/* test/mdbc_bus_master.sv */
// bus master model: periodic data exchange with the unit
`timescale 1ns/1ps
module mdbc_bus_master #(
    parameter int PERIOD = 4
) (
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic [3:0] WANT,
    output      logic       XCHG,
    output      logic [3:0] OUT_BITS
);
    logic [7:0] cnt;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cnt      <= 8'h00;
            XCHG     <= 1'b0;
            OUT_BITS <= 4'h0;
        end else begin
            cnt      <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
            XCHG     <= (cnt == 8'h00);
            // bits only count during an exchange, scrambled in between
            OUT_BITS <= (cnt == 8'h00) ? WANT : ~WANT;
        end
    end
endmodule

/* test/mdbc_top_properties.sv */
// port checks of the motor drive bus control block
`timescale 1ns/1ps
`include "mdbc_defines.svh"
module mdbc_top_properties #(
    parameter int TICK_CYC = `MDBC_TICK_CYC
) (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        XCHG,
    input wire logic [3:0]  OUT_BITS,
    input wire logic [3:0]  IN_BITS,
    input wire logic [1:0]  KEY_POS,
    input wire logic [5:0]  PWR_FAULT,
    input wire logic        MOTOR_FAULT,
    input wire logic        RUN_CW,
    input wire logic        RUN_CCW,
    input wire logic [5:0]  REF_FREQ,
    input wire logic        COAST,
    input wire logic        RAMP_STOP,
    input wire logic        MOTOR_DIAG,
    input wire logic [15:0] ACC_TIME,
    input wire logic [15:0] DEC_TIME
);
    localparam int KEY_TICKS = `MDBC_KEY_TICKS;
    logic [31:0] off_cnt;
    logic        auto_k;
    logic        off_k;
    assign auto_k = (KEY_POS == mdbc_pkg::MDBC_KEY_AUTO);
    assign off_k  = (KEY_POS == mdbc_pkg::MDBC_KEY_OFF);
    // cycles the key has stood in off without a break
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            off_cnt <= 32'h0;
        end else begin
            off_cnt <= off_k ? off_cnt + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence both_dir_s;
        XCHG && auto_k && OUT_BITS[1:0] == 2'h3 ##1 auto_k ##1 auto_k;
    endsequence
    sequence fix_freq_s;
        XCHG && auto_k && OUT_BITS[3:2] != 2'h0 ##1 auto_k ##1 auto_k;
    endsequence
    function automatic logic [5:0] fix_hz(input logic [3:0] b);
        return (b[3:2] == 2'h1) ? 6'h1E : ((b[3:2] == 2'h2) ? 6'h28 : 6'h32);
    endfunction
    dir_excl_a: assert property (!(RUN_CW && RUN_CCW))
        else $error("both run outputs high");
    both_dir_a: assert property (both_dir_s |-> !RUN_CW && !RUN_CCW)
        else $error("run with both direction bits");
    fix_freq_a: assert property (fix_freq_s |-> REF_FREQ == fix_hz($past(OUT_BITS, 2)))
        else $error("fixed frequency wrong");
    grp_bit_a: assert property (XCHG && COAST |=> !IN_BITS[1])
        else $error("group error not reported");
    coast_drive_a: assert property (COAST [*2] |-> !RUN_CW && !RUN_CCW)
        else $error("drive kept during coast");
    ramp_stop_a: assert property (RAMP_STOP |-> (!COAST && MOTOR_DIAG) ##1 (!RUN_CW && !RUN_CCW))
        else $error("ramp stop inconsistent");
    short_press_a: assert property ($fell(COAST) && off_k |-> off_cnt >= (KEY_TICKS - 2) * TICK_CYC)
        else $error("short key press cleared error");
    key_bound_a: assert property (off_k && off_cnt > (KEY_TICKS + 2) * TICK_CYC && PWR_FAULT == 6'h00
        && !MOTOR_FAULT |-> !COAST && !MOTOR_DIAG)
        else $error("key hold did not clear error");
    ramp_dflt_a: assert property ($past(RST) |-> ACC_TIME == 16'h0064 && DEC_TIME == 16'h0014)
        else $error("ramp defaults wrong");
    in_hold_a: assert property ($changed(IN_BITS) |-> $past(XCHG))
        else $error("input bits moved without exchange");
endmodule
bind mdbc_top mdbc_top_properties #(.TICK_CYC(TICK_CYC)) mdbc_top_properties_i (
    .CLK(CLK), .RST(RST), .XCHG(XCHG), .OUT_BITS(OUT_BITS), .IN_BITS(IN_BITS), .KEY_POS(KEY_POS),
    .PWR_FAULT(PWR_FAULT), .MOTOR_FAULT(MOTOR_FAULT), .RUN_CW(RUN_CW), .RUN_CCW(RUN_CCW),
    .REF_FREQ(REF_FREQ), .COAST(COAST), .RAMP_STOP(RAMP_STOP), .MOTOR_DIAG(MOTOR_DIAG),
    .ACC_TIME(ACC_TIME), .DEC_TIME(DEC_TIME));

/* test/test_motor_drive_bus_control.sv */
// self-checking bench of the motor drive bus control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin error_cnt++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module test_motor_drive_bus_control;
    localparam int         TICK     = 4;
    localparam logic [1:0] key_auto = mdbc_pkg::MDBC_KEY_AUTO;
    localparam logic [1:0] key_hand = mdbc_pkg::MDBC_KEY_HAND;
    logic clk, rst = 1'b1, xchg, wr = 1'b0, rd = 1'b0, hand_cw = 1'b0, supply_ok = 1'b1, motor_fault = 1'b0;
    logic ext_a = 1'b0, ext_b = 1'b0, run_cw, run_ccw, coast, ramp_stop, motor_diag, irq;
    logic hand_ccw = 1'b0, selftest = 1'b0, swap = 1'b0;
    logic [3:0]  want = 4'h0, out_bits, in_bits, b;
    logic [1:0]  key_pos = key_auto;
    logic [5:0]  pwr_fault = 6'h00, pot = 6'h00, ref_freq;
    logic [15:0] acc_time, dec_time, lf = 16'h7A06;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    int          error_cnt = 0, tests_run = 0, i;
    mdbc_top #(.TICK_CYC(TICK)) mdbc_top_i (.CLK(clk), .RST(rst || swap), .XCHG(xchg), .OUT_BITS(out_bits),
        .IN_BITS(in_bits), .KEY_POS(key_pos), .HAND_CW(hand_cw), .HAND_CCW(hand_ccw), .SELFTEST_DONE(selftest),
        .SUPPLY_OK(supply_ok), .PWR_FAULT(pwr_fault), .MOTOR_FAULT(motor_fault), .EXTERNAL_INPUT_A(ext_a),
        .EXTERNAL_INPUT_B(ext_b), .POT_FREQ(pot), .RUN_CW(run_cw), .RUN_CCW(run_ccw), .REF_FREQ(ref_freq),
        .COAST(coast), .RAMP_STOP(ramp_stop), .MOTOR_DIAG(motor_diag), .ACC_TIME(acc_time),
        .DEC_TIME(dec_time), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq));
    mdbc_bus_master #(.PERIOD(4)) mdbc_bus_master_i (.CLK(clk), .RST(rst), .WANT(want), .XCHG(xchg),
        .OUT_BITS(out_bits));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [5:0] exp_freq(input logic [3:0] c, input logic [5:0] p);
        return (c[3:2] == 2'h1) ? 6'h1E : (c[3:2] == 2'h2) ? 6'h28 : (c[3:2] == 2'h3) ? 6'h32 :
            ((p > 6'h32) ? 6'h32 : p);
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk) begin addr <= a; wdata <= v; wr <= 1'b1; end
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk) begin addr <= a; rd <= 1'b1; end
        @(posedge clk) rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic hold_off(input int n);
        @(posedge clk) key_pos <= mdbc_pkg::MDBC_KEY_OFF;
        cyc(n);
    endtask
    task automatic bus_seq(input int hi);
        @(posedge clk) want <= 4'h0;
        cyc(170);
        @(posedge clk) want <= 4'h3;
        cyc(hi);
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        `CHK("in_bits", 4'h2, in_bits)
        `CHK("acc", 16'h0064, acc_time)
        `CHK("dec", 16'h0014, dec_time)
        @(posedge clk) pwr_fault <= 6'h08;
        @(posedge clk) begin pwr_fault <= 6'h00; selftest <= 1'b1; end
        cyc(2);
        `CHK("pre_test", 1'b0, coast)
        rd_reg(8'hFC);
        `CHK("unmapped", 32'h0, d)
        wr_reg(8'h04, 32'h0123);
        rd_reg(8'h04);
        `CHK("acc_rd", 32'h0123, d)
        for (i = 0; i < 32; i++) begin
            lf = lfsr(lf);
            b = 4'(i);
            @(posedge clk) begin want <= b; pot <= (i == 16) ? 6'h3F : lf[5:0]; end
            cyc(12);
            `CHK("run_cw", b[0] & ~b[1], run_cw)
            `CHK("run_ccw", b[1] & ~b[0], run_ccw)
            `CHK("ref_freq", exp_freq(b, pot), ref_freq)
        end
        wr_reg(8'h00, 32'h2);
        for (i = 0; i < 8; i++) begin
            lf = lfsr(lf);
            @(posedge clk) begin ext_a <= lf[0]; ext_b <= lf[1]; key_pos <= lf[2] ? key_auto : key_hand; end
            cyc(10);
            `CHK("in_bits", {lf[1], lf[0], 1'b1, lf[2]}, in_bits)
        end
        @(posedge clk) begin key_pos <= key_auto; want <= 4'h1; pwr_fault <= 6'h04; end
        @(posedge clk) pwr_fault <= 6'h00;
        wr_reg(8'h14, 32'h1);
        cyc(12);
        `CHK("coast", 1'b1, coast)
        `CHK("run_cw", 1'b0, run_cw)
        `CHK("grp", 1'b0, in_bits[1])
        `CHK("irq", 1'b1, irq)
        rd_reg(8'h18);
        `CHK("fault_reg", 32'h04, d)
        wr_reg(8'h10, 32'h1);
        cyc(1);
        `CHK("irq_clr", 1'b0, irq)
        hold_off(2000);
        `CHK("short_key", 1'b1, coast)
        @(posedge clk) key_pos <= key_auto;
        hold_off(4100);
        `CHK("key_clr", 1'b0, coast)
        @(posedge clk) key_pos <= key_auto;
        cyc(12);
        `CHK("resume", 1'b1, run_cw)
        wr_reg(8'h00, 32'h3);
        @(posedge clk) motor_fault <= 1'b1;
        @(posedge clk) motor_fault <= 1'b0;
        cyc(12);
        `CHK("ramp", 1'b1, ramp_stop)
        `CHK("coast_enh", 1'b0, coast)
        `CHK("diag", 1'b1, motor_diag)
        bus_seq(80);
        `CHK("short_seq", 1'b1, motor_diag)
        bus_seq(170);
        `CHK("seq_clr", 1'b0, motor_diag)
        `CHK("seq_run", 1'b0, run_cw)
        rd_reg(8'h10);
        `CHK("seq_irq", 1'b1, d[2])
        @(posedge clk) begin want <= 4'h0; key_pos <= key_hand; supply_ok <= 1'b0; end
        cyc(4);
        @(posedge clk) begin supply_ok <= 1'b1; hand_cw <= 1'b1; end
        cyc(12);
        `CHK("blk_run", 1'b0, run_cw)
        rd_reg(8'h0C);
        `CHK("blocked", 1'b1, d[9])
        hold_off(8);
        rd_reg(8'h0C);
        `CHK("unblocked", 1'b0, d[9])
        @(posedge clk) begin hand_cw <= 1'b0; hand_ccw <= 1'b1; key_pos <= key_hand; end
        cyc(4);
        `CHK("hand_ccw", 1'b1, run_ccw)
        @(posedge clk) begin swap <= 1'b1; key_pos <= key_auto; end
        cyc(4);
        @(posedge clk) swap <= 1'b0;
        cyc(12);
        `CHK("swap_acc", 16'h0064, acc_time)
        `CHK("swap_in", 4'h3, in_bits)
        end_of_test();
    end
endmodule
